// *** rtl/burst_pkg.sv ***
// Shared constants and state types for the 16-bit burst bus sequencer and responder.
package burst_pkg;
  localparam int DATA_BITS = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int CLOCK_HZ = 20_000_000;
  localparam logic [2:0] LINE_LAST_CYCLE = 3'h7;
  localparam logic [3:0] LINE_FIRST_BYTE = 4'h0;
  localparam logic [3:0] LINE_LAST_BYTE = 4'hf;
  localparam logic [3:0] LANES_IDLE = 4'hf;
  localparam logic [1:0] QUAD_LAST_HALF = 2'h3;
  typedef enum logic [2:0] {st_idle, st_setup, st_present, st_strobe, st_data} seq_state_e;
  typedef enum logic [1:0] {rs_idle, rs_access, rs_answer} resp_state_e;
endpackage

// *** rtl/burst_bus_if.sv ***
// Bus between the burst sequencer and the external memory and I/O port controller.
`timescale 1ns/10ps
interface burst_bus_if;
  logic address_strobe_n;
  logic burst_final_n;
  logic [3:0] byte_lane_enables_n;
  logic [31:2] addr;
  logic mem_io;
  logic write_read;
  logic data_code;
  logic page_cache_disable;
  logic lock_n;
  logic cacheable_input_n;
  logic ready_n;
  logic [15:0] wdata;
  logic device_data_oe;
  logic [15:0] rdata;
  logic ctrl_data_oe;
  logic [15:0] data;

  // The shared data wire resolves here; a bus with nobody driving reads as zero.
  assign data = device_data_oe ? wdata : (ctrl_data_oe ? rdata : 16'h0000);

  modport device(
    output address_strobe_n, burst_final_n, byte_lane_enables_n, addr, mem_io, write_read,
    output data_code, page_cache_disable, lock_n, wdata, device_data_oe,
    input cacheable_input_n, ready_n, data
  );
  modport controller(
    input address_strobe_n, burst_final_n, byte_lane_enables_n, addr, mem_io, write_read,
    input data_code, page_cache_disable, lock_n, data,
    output cacheable_input_n, ready_n, rdata, ctrl_data_oe
  );
endinterface

// *** rtl/stream_fifo.sv ***
// Small flop-based FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module stream_fifo #(
  parameter int WIDTH = burst_pkg::DATA_BITS,
  parameter int DEPTH = burst_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : depth_check
    $error("stream_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = level != LW'(DEPTH);
  assign out_valid = level != '0;
  assign out_data = store[rd_ptr];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      level <= level + LW'(push) - LW'(pop);
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule

// *** rtl/burst_sequencer.sv ***
// Processor-side end: splits memory and I/O transfers into burst and single bus cycles.
// Function
// RULE1: cycle count follows length, start and alignment.
// RULE2: cacheable memory reads use line-fill order.
// RULE3: bursts, mixed, or single cycles each strobed.
// RULE4: I/O and write bursts: two cycles, four bytes.
// RULE5: write bursts hold controls and upper address.
// RULE6: aligned write burst: all lanes, then 0011.
// RULE7: odd write burst: 0001/1001, then 0011/1011.
// RULE8: uncached reads burst at most sixteen bytes.
// RULE9: sixteen-byte prefetch uses line-fill order.
// RULE10: final-cycle signal may end any burst.
// RULE11: short bursts stay inside one quad-word.
// RULE12: address and lanes shown before the strobe.
// RULE13: controller derives bit 1, byte enables.
// RULE14: controller predicts next address at start.
// RULE15: predicted upper bits direct; bit 2 alternates.
// RULE16: controller saves initial bits 3 and 2.
// RULE17: lower enable active, controls steady in burst.
// RULE18: upper enable active except decoded final cycle.
// RULE19: cacheable needs no disable, no lock, enable.
// RULE20: line fill first cycle ignores lane enables.
// RULE21: line fill is eight 16-bit cycles.
// RULE22: predicted bit 3 follows quad-word wrap order.
`timescale 1ns/10ps
module burst_sequencer #(
  parameter int FIFO_DEPTH = burst_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  burst_bus_if.device bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [31:0] req_addr,
  input wire logic [4:0] req_len,
  input wire logic req_mem,
  input wire logic req_write,
  input wire logic req_code,
  input wire logic req_no_cache,
  input wire logic req_lock,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [15:0] wr_data,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic done
);
  localparam int LW = $clog2(FIFO_DEPTH + 1);

  if (FIFO_DEPTH < 2) begin : depth_check
    $error("burst_sequencer needs room for a two-cycle write burst");
  end

  burst_pkg::seq_state_e state;
  logic [31:4] base;
  logic [3:0] first;
  logic [3:0] last;
  logic [3:0] pos;
  logic [2:0] k;
  logic is_write;
  logic line;
  logic no_cache;
  logic locked;
  logic [LW-1:0] level;
  logic fifo_out_valid;

  // Byte address of a line-order cycle: quad halves wrap around the start.
  function automatic logic [3:0] line_pos(input logic [3:0] start, input logic [2:0] idx);
    return {start[3:2] ^ idx[2:1], idx[0], 1'b0};
  endfunction

  // Active-low lanes for the bytes from p to lim inside p's doubleword.
  function automatic logic [3:0] lanes_n(input logic [3:0] p, input logic [3:0] lim);
    logic [3:0] b;
    logic [3:0] r;
    r = burst_pkg::LANES_IDLE;
    for (int i = 0; i < 4; i++) begin
      b = {p[3:2], 2'(i)};
      r[i] = !(b >= p && b <= lim);
    end
    return r;
  endfunction

  // True when the cycle at p is the last of its burst group.
  function automatic logic group_end(input logic [3:0] p, input logic [2:0] idx, input logic ln,
                                     input logic wr, input logic [3:0] lim);
    if (ln) begin
      return idx == burst_pkg::LINE_LAST_CYCLE;
    end
    return (p[3:1] == lim[3:1]) || (wr ? p[1] : (p[2:1] == burst_pkg::QUAD_LAST_HALF));
  endfunction

  // Requests that run one to sixteen bytes past the line end are cut at the line end; longer ones wrap.
  wire [4:0] req_end = {1'b0, req_addr[3:0]} + req_len - 5'h01;
  wire [3:0] clamp_end = req_end[4] ? burst_pkg::LINE_LAST_BYTE : req_end[3:0];

  wire ken = !bus.cacheable_input_n;
  wire is_read_mem = bus.mem_io && !is_write;
  wire cacheable = !no_cache && !locked && ken; // [RULE19]
  wire whole_line = first == burst_pkg::LINE_FIRST_BYTE && last == burst_pkg::LINE_LAST_BYTE;
  wire line_pick = is_read_mem && (cacheable || (whole_line && bus.data_code)); // [RULE2] [RULE9]
  wire line_use = (state == burst_pkg::st_setup) ? line_pick : line;
  wire [3:0] lim = line_use ? burst_pkg::LINE_LAST_BYTE : last;
  wire [3:0] p_now = line_use ? line_pos(first, k) : pos;
  wire [2:0] k_nx = k + 3'h1;
  // I/O reads share the doubleword limit of writes, so they group like writes. [RULE4]
  wire short_burst = is_write || !bus.mem_io;
  wire [3:0] p_nx = line ? line_pos(first, k_nx) : {pos[3:1] + 3'h1, 1'b0}; // [RULE1]
  // Writes and I/O group per doubleword, uncached memory reads other than the sixteen-byte code prefetch per quad-word. [RULE4] [RULE8] [RULE11]
  wire fin_now = group_end(p_now, k, line_use, short_burst, lim);
  wire fin_nx = group_end(p_nx, k_nx, line, short_burst, lim);
  wire xfer_last = line ? (k == burst_pkg::LINE_LAST_CYCLE) : (pos[3:1] == last[3:1]);
  wire took = state == burst_pkg::st_data && !bus.ready_n;
  wire group_done = !bus.burst_final_n;
  // A group starting on an even halfword has two words unless the transfer ends in its lower half.
  wire two_words = !p_now[1] && (last[3:2] != p_now[3:2] || last[1]);
  wire [LW-1:0] need = two_words ? LW'(2) : LW'(1);
  // A write burst cannot be paused by this end, so its words must be queued first.
  wire wr_short = is_write && (level < need);
  wire fifo_pop = took && is_write;

  stream_fifo #(
    .WIDTH(burst_pkg::DATA_BITS),
    .DEPTH(FIFO_DEPTH)
  ) write_queue (
    .clock(clock),
    .rst(rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(bus.wdata),
    .level(level)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= burst_pkg::st_idle;
      req_ready <= 1'b1;
      done <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
      base <= '0;
      first <= 4'h0;
      last <= 4'h0;
      pos <= 4'h0;
      k <= 3'h0;
      is_write <= 1'b0;
      line <= 1'b0;
      no_cache <= 1'b0;
      locked <= 1'b0;
      bus.address_strobe_n <= 1'b1;
      bus.burst_final_n <= 1'b1;
      bus.byte_lane_enables_n <= burst_pkg::LANES_IDLE;
      bus.addr <= '0;
      bus.mem_io <= 1'b0;
      bus.write_read <= 1'b0;
      bus.data_code <= 1'b0;
      bus.page_cache_disable <= 1'b0;
      bus.lock_n <= 1'b1;
      bus.device_data_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      rd_valid <= 1'b0;
      unique case (state)
        burst_pkg::st_idle: begin
          if (req_valid) begin
            base <= req_addr[31:4];
            first <= req_addr[3:0];
            last <= clamp_end;
            pos <= req_addr[3:0];
            k <= 3'h0;
            is_write <= req_write;
            no_cache <= req_no_cache;
            locked <= req_lock;
            // Controls stay put for the whole transfer. [RULE5] [RULE17]
            bus.mem_io <= req_mem;
            bus.write_read <= req_write;
            bus.data_code <= req_code;
            bus.page_cache_disable <= req_no_cache;
            bus.lock_n <= !req_lock;
            req_ready <= 1'b0;
            state <= burst_pkg::st_setup;
          end
        end
        burst_pkg::st_setup: begin
          if (!wr_short) begin
            line <= line_pick; // [RULE21]
            bus.addr <= {base, p_now[3:2]};
            bus.byte_lane_enables_n <= lanes_n(p_now, lim); // [RULE6] [RULE7]
            bus.burst_final_n <= !fin_now;
            state <= burst_pkg::st_present;
          end
        end
        burst_pkg::st_present: begin
          // Address and lanes were driven a full cycle ahead of the strobe. [RULE12]
          bus.address_strobe_n <= 1'b0; // [RULE3]
          state <= burst_pkg::st_strobe;
        end
        burst_pkg::st_strobe: begin
          bus.address_strobe_n <= 1'b1;
          bus.device_data_oe <= is_write;
          state <= burst_pkg::st_data;
        end
        burst_pkg::st_data: begin
          if (took) begin
            rd_valid <= !is_write;
            rd_data <= bus.data;
            k <= k_nx;
            pos <= p_nx;
            if (xfer_last) begin
              bus.burst_final_n <= 1'b1;
              bus.byte_lane_enables_n <= burst_pkg::LANES_IDLE;
              bus.device_data_oe <= 1'b0;
              req_ready <= 1'b1;
              done <= 1'b1;
              state <= burst_pkg::st_idle;
            end else if (group_done) begin
              // The final-cycle signal closed this burst; a fresh strobe opens the next. [RULE10] [RULE3]
              bus.device_data_oe <= 1'b0;
              state <= burst_pkg::st_setup;
            end else begin
              // Only bits 3 and 2 may move inside a read burst. [RULE11] [RULE5]
              bus.addr <= {base, p_nx[3:2]};
              bus.byte_lane_enables_n <= lanes_n(p_nx, lim); // [RULE6] [RULE7]
              bus.burst_final_n <= !fin_nx; // [RULE10]
            end
          end
        end
      endcase
    end
  end
endmodule

// *** rtl/burst_responder.sv ***
// Controller-side end: answers bus cycles and predicts each next burst address.
`timescale 1ns/10ps
module burst_responder (
  input wire logic clock,
  input wire logic rst,
  burst_bus_if.controller bus,
  input wire logic cacheable_region,
  output logic mem_valid,
  output logic [31:4] mem_addr_upper,
  output logic predicted_addr_bit3,
  output logic predicted_addr_bit2,
  output logic predicted_addr_bit1,
  output logic saved_initial_addr_bit3,
  output logic saved_initial_addr_bit2,
  output logic upper_byte_enable_n,
  output logic lower_byte_enable_n,
  output logic mem_write,
  output logic mem_is_memory,
  output logic mem_is_code,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  burst_pkg::resp_state_e state;
  logic first;
  logic fill;
  logic last;

  wire [3:0] lanes = bus.byte_lane_enables_n;
  wire first_a1 = lanes[1:0] == 2'h3; // [RULE13]
  wire at_final = !bus.burst_final_n;
  wire first_upper_n = lanes[{first_a1, 1'b1}];
  wire first_lower_n = lanes[{first_a1, 1'b0}];
  wire later_upper_n = at_final ? lanes[{predicted_addr_bit1, 1'b1}] : 1'b0; // [RULE18]

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= burst_pkg::rs_idle;
      first <= 1'b0;
      fill <= 1'b0;
      last <= 1'b0;
      mem_valid <= 1'b0;
      mem_addr_upper <= '0;
      predicted_addr_bit3 <= 1'b0;
      predicted_addr_bit2 <= 1'b0;
      predicted_addr_bit1 <= 1'b0;
      saved_initial_addr_bit3 <= 1'b0;
      saved_initial_addr_bit2 <= 1'b0;
      upper_byte_enable_n <= 1'b1;
      lower_byte_enable_n <= 1'b1;
      mem_write <= 1'b0;
      mem_is_memory <= 1'b0;
      mem_is_code <= 1'b0;
      mem_wdata <= 16'h0000;
      bus.cacheable_input_n <= 1'b1;
      bus.ready_n <= 1'b1;
      bus.rdata <= 16'h0000;
      bus.ctrl_data_oe <= 1'b0;
    end else begin
      bus.cacheable_input_n <= !cacheable_region;
      unique case (state)
        burst_pkg::rs_idle: begin
          if (!bus.address_strobe_n) begin
            mem_addr_upper <= bus.addr[31:4]; // [RULE15]
            saved_initial_addr_bit3 <= bus.addr[3]; // [RULE16]
            saved_initial_addr_bit2 <= bus.addr[2]; // [RULE16]
            predicted_addr_bit3 <= bus.addr[3];
            predicted_addr_bit2 <= bus.addr[2];
            mem_write <= bus.write_read; // [RULE17]
            mem_is_memory <= bus.mem_io;
            mem_is_code <= bus.data_code;
            // Only a cycle the device itself treats as cacheable is a line fill. [RULE20]
            fill <= !bus.cacheable_input_n && !bus.page_cache_disable && bus.lock_n && bus.mem_io && !bus.write_read;
            first <= 1'b1;
            state <= burst_pkg::rs_access;
          end
        end
        burst_pkg::rs_access: begin
          if (!mem_valid) begin
            // Start the memory access as soon as the address is known. [RULE14]
            mem_valid <= 1'b1;
            mem_wdata <= bus.data;
            if (first) begin
              // A line fill starts on the halfword at the doubleword base. [RULE20]
              predicted_addr_bit1 <= fill ? 1'b0 : first_a1; // [RULE13]
              lower_byte_enable_n <= fill ? 1'b0 : first_lower_n;
              upper_byte_enable_n <= fill ? 1'b0 : first_upper_n;
            end else begin
              lower_byte_enable_n <= 1'b0; // [RULE17]
              upper_byte_enable_n <= later_upper_n; // [RULE18]
            end
          end else if (mem_ack) begin
            mem_valid <= 1'b0;
            bus.rdata <= mem_rdata;
            bus.ctrl_data_oe <= !mem_write;
            bus.ready_n <= 1'b0;
            last <= at_final;
            state <= burst_pkg::rs_answer;
          end
        end
        burst_pkg::rs_answer: begin
          bus.ready_n <= 1'b1;
          bus.ctrl_data_oe <= 1'b0;
          first <= 1'b0;
          if (last) begin
            state <= burst_pkg::rs_idle;
          end else begin
            predicted_addr_bit1 <= !predicted_addr_bit1;
            if (predicted_addr_bit1) begin
              predicted_addr_bit2 <= !predicted_addr_bit2; // [RULE15]
              // Bit 3 flips once both halves of the starting quad-word are done. [RULE22]
              if (predicted_addr_bit2 != saved_initial_addr_bit2) begin
                predicted_addr_bit3 <= !predicted_addr_bit3;
              end
            end
            state <= burst_pkg::rs_access;
          end
        end
      endcase
    end
  end
endmodule

// *** bench/burst_bus_assertions.sv ***
// Concurrent checks on the bus between the burst sequencer and the burst responder.
`timescale 1ns/10ps
module burst_bus_checker (
  input logic clock,
  input logic rst,
  input logic address_strobe_n,
  input logic burst_final_n,
  input logic [3:0] byte_lane_enables_n,
  input logic [31:2] addr,
  input logic mem_io,
  input logic write_read,
  input logic data_code,
  input logic ready_n
);
  logic [3:0] beats;
  wire short_kind = write_read || !mem_io;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Beats restart at each strobe, so an overlong burst is caught at the beat that overruns it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      beats <= 4'h0;
    else if (!address_strobe_n)
      beats <= 4'h0;
    else if (!ready_n)
      beats <= beats + 4'h1;
  end
  property p_strobe_single;
    !address_strobe_n |=> address_strobe_n;
  endproperty
  a_strobe_single: assert property (p_strobe_single) else $error("strobe longer than one cycle");
  property p_setup_stable;
    $fell(address_strobe_n) |-> $stable(addr) && $stable(byte_lane_enables_n);
  endproperty
  a_setup_stable: assert property (p_setup_stable) else $error("address not shown before strobe");
  property p_ctrl_steady;
    !ready_n && burst_final_n |=> $stable(mem_io) && $stable(write_read) && $stable(data_code) && $stable(addr[31:4]);
  endproperty
  a_ctrl_steady: assert property (p_ctrl_steady) else $error("controls moved inside burst");
  property p_write_addr;
    !ready_n && burst_final_n && short_kind |=> $stable(addr[31:2]);
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("address moved in short burst");
  property p_write_second;
    !ready_n && burst_final_n && short_kind |=> !burst_final_n && byte_lane_enables_n inside {4'h3, 4'hb};
  endproperty
  a_write_second: assert property (p_write_second) else $error("bad second cycle of short burst");
  property p_write_first;
    $fell(address_strobe_n) && burst_final_n && short_kind |-> byte_lane_enables_n inside {4'h0, 4'h1, 4'h8, 4'h9};
  endproperty
  a_write_first: assert property (p_write_first) else $error("bad first lanes of short burst");
  property p_fill_beats;
    !ready_n |-> beats < 4'h8;
  endproperty
  a_fill_beats: assert property (p_fill_beats) else $error("burst longer than eight cycles");
  property p_write_beats;
    !ready_n && short_kind |-> beats < 4'h2;
  endproperty
  a_write_beats: assert property (p_write_beats) else $error("short burst over two cycles");
endmodule

// *** bench/burst_cycle_sequencing_16bit_test.sv ***
// Bench joining the burst sequencer and burst responder through the bus interface.
`timescale 1ns/10ps
module burst_cycle_sequencing_16bit_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0, req_mem = 1'b0, req_write = 1'b0, req_code = 1'b0;
  logic req_no_cache = 1'b0, req_lock = 1'b0, wr_valid = 1'b0, cacheable_region = 1'b0, mem_ack = 1'b0;
  logic [31:0] req_addr = 32'h0;
  logic [4:0] req_len = 5'h1;
  logic [15:0] wr_data = 16'h0, mem_rdata = 16'h0, rd_data, mem_wdata;
  logic req_ready, wr_ready, rd_valid, done, mem_valid, mem_write, mem_is_memory, mem_is_code;
  logic predicted_addr_bit3, predicted_addr_bit2, predicted_addr_bit1;
  logic saved_initial_addr_bit3, saved_initial_addr_bit2, upper_byte_enable_n, lower_byte_enable_n;
  logic [31:4] mem_addr_upper;
  logic [15:0] rd_q[$];
  logic [22:0] acc_q[$];
  logic [1:0] stall = 2'h0;
  int error_cnt = 0, n_tests = 0, cycle_cnt = 0;
  burst_bus_if bus();
  burst_sequencer i_burst_sequencer (.clock(clock), .rst(rst), .bus(bus), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .req_len(req_len), .req_mem(req_mem), .req_write(req_write),
    .req_code(req_code), .req_no_cache(req_no_cache), .req_lock(req_lock), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done));
  burst_responder i_burst_responder (.clock(clock), .rst(rst), .bus(bus), .cacheable_region(cacheable_region),
    .mem_valid(mem_valid), .mem_addr_upper(mem_addr_upper), .predicted_addr_bit3(predicted_addr_bit3),
    .predicted_addr_bit2(predicted_addr_bit2), .predicted_addr_bit1(predicted_addr_bit1),
    .saved_initial_addr_bit3(saved_initial_addr_bit3), .saved_initial_addr_bit2(saved_initial_addr_bit2),
    .upper_byte_enable_n(upper_byte_enable_n), .lower_byte_enable_n(lower_byte_enable_n),
    .mem_write(mem_write), .mem_is_memory(mem_is_memory), .mem_is_code(mem_is_code),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  burst_bus_checker i_burst_bus_checker (.clock(clock), .rst(rst), .address_strobe_n(bus.address_strobe_n),
    .burst_final_n(bus.burst_final_n), .byte_lane_enables_n(bus.byte_lane_enables_n), .addr(bus.addr),
    .mem_io(bus.mem_io), .write_read(bus.write_read), .data_code(bus.data_code), .ready_n(bus.ready_n));
  always #25 clock = ~clock;
  // Memory stalls each access so the write FIFO drains against a slow far side.
  always @(posedge clock) begin
    cycle_cnt <= cycle_cnt + 1;
    mem_ack <= 1'b0;
    if (mem_valid && !mem_ack) begin
      stall <= stall + 2'h1;
      if (stall == 2'h2) begin
        stall <= 2'h0;
        mem_ack <= 1'b1;
        mem_rdata <= {mem_addr_upper[15:4], predicted_addr_bit3, predicted_addr_bit2, predicted_addr_bit1, 1'b0};
        acc_q.push_back({mem_write, mem_is_memory, upper_byte_enable_n, lower_byte_enable_n,
          predicted_addr_bit3, predicted_addr_bit2, predicted_addr_bit1, mem_wdata});
        check(bus.addr[3:2], {predicted_addr_bit3, predicted_addr_bit2});
      end
    end
    if (rd_valid)
      rd_q.push_back(rd_data);
    if (cycle_cnt == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [31:0] a, input logic [4:0] n, input logic [5:0] kind);
    do @(negedge clock); while (req_ready !== 1'b1);
    @(posedge clock);
    req_valid <= 1'b1;
    req_addr <= a;
    req_len <= n;
    {cacheable_region, req_lock, req_no_cache, req_code, req_write, req_mem} <= kind;
    @(posedge clock);
    req_valid <= 1'b0;
    do @(negedge clock); while (done !== 1'b1);
    @(negedge clock);
  endtask
  task automatic push(input logic [15:0] w);
    @(posedge clock);
    wr_valid <= 1'b1;
    wr_data <= w;
    do @(negedge clock); while (wr_ready !== 1'b1);
    @(posedge clock);
    wr_valid <= 1'b0;
  endtask
  task automatic t_fill;
    for (int s = 0; s < 16; s += 4) begin
      rd_q = {};
      acc_q = {};
      run(32'h0000_1230 + s, 5'h2, 6'h21);
      check(rd_q.size(), 8);
      check({saved_initial_addr_bit3, saved_initial_addr_bit2}, s[3:2]);
      for (int k = 0; k < 8; k++) begin
        check(rd_q[k], 16'h1230 | {s[3] ^ k[2], s[2] ^ k[1], k[0], 1'b0});
        check(acc_q[k][20:19], 2'h0);
      end
    end
    $display("line fill test finished");
  endtask
  task automatic t_reads;
    logic [5:0] kinds [6] = '{6'h05, 6'h01, 6'h31, 6'h29, 6'h20, 6'h00};
    logic [4:0] lens [6] = '{5'h10, 5'h10, 5'h2, 5'h2, 5'h4, 5'h8};
    logic [3:0] starts [6] = '{4'h0, 4'h0, 4'h8, 4'ha, 4'h0, 4'h0};
    for (int i = 0; i < 6; i++) begin
      rd_q = {};
      run(32'h0000_1230 + starts[i], lens[i], kinds[i]);
      check(rd_q.size(), lens[i] / 2);
      check(mem_is_code, kinds[i][2]);
      check(mem_addr_upper, 28'h0000123);
      for (int k = 0; k < rd_q.size(); k++)
        check(rd_q[k], 16'h1230 + starts[i] + 2 * k);
    end
    $display("uncached read test finished");
  endtask
  task automatic wr_case(input logic [31:0] a, input logic [4:0] n, input logic [5:0] kind, input logic [22:0] e[$]);
    acc_q = {};
    foreach (e[i]) push(e[i][15:0]);
    @(negedge clock);
    check(wr_ready, e.size() != 4);
    run(a, n, kind);
    check(acc_q.size(), e.size());
    foreach (e[i]) check(acc_q[i], e[i]);
  endtask
  task automatic t_writes;
    wr_case(32'h0000_1230, 5'h8, 6'h03, {23'h60a000, 23'h61a001, 23'h62a002, 23'h63a003});
    wr_case(32'h0000_1231, 5'h3, 6'h03, {23'h68b100, 23'h61b2b3});
    wr_case(32'h0000_1234, 5'h4, 6'h02, {23'h42c004, 23'h43c006});
    $display("write test finished");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_fill();
    t_reads();
    t_writes();
    end_of_test();
  end
endmodule
